// [rtl/uart_ctl_pkg.sv]
// Register map, field positions and constants of the serial port control block
`default_nettype none
package uart_ctl_pkg;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ICTL = 8'h08;
  localparam logic [7:0] OFS_TXBUF = 8'h0C;
  localparam logic [7:0] OFS_RXBUF = 8'h10;
  // mode_select_one fields
  localparam int MD_ATN = 1;
  localparam int MD_BRK = 2;
  localparam int MD_TXDMA = 4;
  localparam int MD_RXDMA = 5;
  localparam int MD_FCE = 6;
  localparam int MD_RTS = 7;
  localparam logic [7:0] MODE_WMASK = 8'hF6;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // line_status fields
  localparam int ST_PE = 1;
  localparam int ST_FE = 2;
  localparam int ST_OE = 3;
  localparam int ST_ERR = 4;
  localparam int ST_BKD = 5;
  localparam int ST_RB9 = 6;
  localparam int ST_TIP = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // interrupt_control fields
  localparam int IC_TBE = 0;
  localparam int IC_RBF = 1;
  localparam int IC_FCI = 2;
  localparam int IC_TXI = 3;
  localparam int IC_RXI = 4;
  localparam int IC_EEI = 5;
  localparam int IC_DCTS = 6;
  localparam int IC_CTS = 7;
  localparam logic [3:0] ICTL_EN_RESET = 4'h0;
  localparam logic [7:0] ICTL_RESET = 8'h01;
  // Bit times the line must stay low after a missing stop bit
  localparam int BREAK_BITS = 10;
endpackage : uart_ctl_pkg
`default_nettype wire

// [rtl/uart_mode_status_irq_ctrl.sv]
// Mode, status and interrupt control registers of an asynchronous serial port
// Behaviour
// - Address frame clears attention mode bit
// - Receive DMA suppresses receive full interrupt
// - Ready-to-send output is inverted control bit
// - Status register read-only, writes ignored
// - Transmit in progress follows shifting activity
// - Parity error set, cleared by status read
// - Framing error set, cleared by status read
// - Overrun set, cleared by status read
// - Error summary is OR of three errors
// - Break after ten low bit times
// - Break clears only once line is high
// - Ninth received bit captured in status
// - Interrupt control resets to one, mixed access
// - Buffer empty set on load, cleared by write
// - Buffer full set on frame, cleared by read
// - Clear-to-send change flag, cleared by read
// - Clear-to-send state is inverted input
// - Flow interrupt on change flag rising
// - Transmit interrupt on empty flag rising
// - Receive interrupt on full flag rising
// - Error interrupt on summary flag rising
`default_nettype none
module uart_mode_status_irq_ctrl
  import uart_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  input wire logic cts_n_pin,
  input wire logic tx_serial,
  input wire logic tx_busy,
  input wire logic tx_load,
  input wire logic rx_done,
  input wire logic [8:0] rx_data,
  input wire logic rx_parity_bad,
  input wire logic rx_stop_bad,
  input wire logic nine_bit_mode,
  input wire logic bit_tick,
  output logic txd_out,
  output logic rts_n_out,
  output logic tx_enable,
  output logic [7:0] tx_data,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic tx_irq,
  output logic rx_irq,
  output logic rx_err_irq,
  output logic flow_irq
);
  import uart_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_reg;
  logic [3:0] ien_reg;
  logic pe_reg, fe_reg, oe_reg, bkd_reg, rb9_reg, tip_reg;
  logic tbe_reg, rbf_reg, dcts_reg;
  logic [7:0] rxbuf_reg;
  logic [7:0] rd_snap_reg;
  logic [1:0] rxd_sync_reg, cts_sync_reg;
  logic cts_prev_reg;
  logic [3:0] brk_cnt_reg;
  logic brk_arm_reg, brk_clr_pend_reg;
  logic err_prev_reg, tbe_prev_reg, rbf_prev_reg, dcts_prev_reg;
  logic rxd_s, cts_state, err_sum;
  logic setup, access, wr, rd, mapped;
  logic [7:0] stat_val, ictl_val, rd_val;

  assign rxd_s = rxd_sync_reg[1];
  assign cts_state = ~cts_sync_reg[1];
  assign err_sum = pe_reg | fe_reg | oe_reg;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & pstrb[0];
  assign rd = access & ~pwrite;
  assign mapped = paddr == OFS_MODE || paddr == OFS_STAT || paddr == OFS_ICTL ||
                  paddr == OFS_TXBUF || paddr == OFS_RXBUF;

  always_comb begin
    stat_val = STAT_RESET;
    stat_val[ST_PE] = pe_reg;
    stat_val[ST_FE] = fe_reg;
    stat_val[ST_OE] = oe_reg;
    stat_val[ST_ERR] = err_sum;
    stat_val[ST_BKD] = bkd_reg;
    stat_val[ST_RB9] = rb9_reg;
    stat_val[ST_TIP] = tip_reg;
    ictl_val = {cts_state, dcts_reg, ien_reg, rbf_reg, tbe_reg};
    case (paddr)
      OFS_MODE: rd_val = mode_reg;
      OFS_STAT: rd_val = stat_val;
      OFS_ICTL: rd_val = ictl_val;
      OFS_RXBUF: rd_val = rxbuf_reg;
      default: rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: data is latched in setup, so every access ends in one wait-free
  // access phase. Status read-to-clear only drops bits that the snapshot showed; a receive buffer read clears rbf_reg unless rx_done comes in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_snap_reg <= 8'h00;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= {24'h00_0000, rd_val};
        rd_snap_reg <= rd_val;
        pslverr <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync_reg <= 2'b11;
      cts_sync_reg <= 2'b11;
      cts_prev_reg <= 1'b1;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_pin};
      cts_sync_reg <= {cts_sync_reg[0], cts_n_pin};
      cts_prev_reg <= cts_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register; a software write wins over the attention auto-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RESET;
    end else if (wr && paddr == OFS_MODE) begin
      mode_reg <= pwdata[7:0] & MODE_WMASK;
    end else if (rx_done && nine_bit_mode && rx_data[8]) begin
      mode_reg[MD_ATN] <= 1'b0;
    end
  end

  // Pin drivers and transmitter hand-offs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      rts_n_out <= 1'b1;
      tx_enable <= 1'b1;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      tip_reg <= 1'b0;
    end else begin
      txd_out <= mode_reg[MD_BRK] ? 1'b0 : tx_serial;
      rts_n_out <= ~mode_reg[MD_RTS];
      tx_enable <= ~mode_reg[MD_FCE] | cts_state;
      tx_dma_req <= mode_reg[MD_TXDMA] & tbe_reg;
      rx_dma_req <= mode_reg[MD_RXDMA] & rbf_reg;
      tip_reg <= tx_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables; status bits of this register ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg <= ICTL_EN_RESET;
    end else if (wr && paddr == OFS_ICTL) begin
      ien_reg <= pwdata[IC_EEI:IC_FCI];
    end
  end

  // Buffers and their flags; hardware set wins over the clearing access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbe_reg <= ICTL_RESET[IC_TBE];
      rbf_reg <= 1'b0;
      tx_data <= 8'h00;
      rxbuf_reg <= 8'h00;
      rb9_reg <= 1'b0;
    end else begin
      if (wr && paddr == OFS_TXBUF) begin
        tx_data <= pwdata[7:0];
      end
      if (tx_load) begin
        tbe_reg <= 1'b1;
      end else if (wr && paddr == OFS_TXBUF) begin
        tbe_reg <= 1'b0;
      end
      if (rx_done) begin
        rbf_reg <= 1'b1;
        rxbuf_reg <= rx_data[7:0];
        rb9_reg <= nine_bit_mode & rx_data[8];
      end else if (rd && paddr == OFS_RXBUF) begin
        rbf_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags; writes to the status offset touch nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      if (rx_done && rx_parity_bad) begin
        pe_reg <= 1'b1;
      end else if (rd && paddr == OFS_STAT && rd_snap_reg[ST_PE]) begin
        pe_reg <= 1'b0;
      end
      if (rx_done && rx_stop_bad) begin
        fe_reg <= 1'b1;
      end else if (rd && paddr == OFS_STAT && rd_snap_reg[ST_FE]) begin
        fe_reg <= 1'b0;
      end
      if (rx_done && rbf_reg && !(rd && paddr == OFS_RXBUF)) begin
        oe_reg <= 1'b1;
      end else if (rd && paddr == OFS_STAT && rd_snap_reg[ST_OE]) begin
        oe_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break detection counts bit ticks of low line after a missing stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_arm_reg <= 1'b0;
      brk_cnt_reg <= 4'h0;
      bkd_reg <= 1'b0;
      brk_clr_pend_reg <= 1'b0;
    end else begin
      if (rx_done && rx_stop_bad) begin
        brk_arm_reg <= 1'b1;
        brk_cnt_reg <= 4'h0;
      end else if (rxd_s) begin
        brk_arm_reg <= 1'b0;
      end else if (brk_arm_reg && bit_tick) begin
        if (brk_cnt_reg == 4'(BREAK_BITS - 1)) begin
          bkd_reg <= 1'b1;
          brk_arm_reg <= 1'b0;
        end
        brk_cnt_reg <= brk_cnt_reg + 4'h1;
      end
      if (rd && paddr == OFS_STAT && rd_snap_reg[ST_BKD]) begin
        brk_clr_pend_reg <= 1'b1;
      end
      if (bkd_reg && rxd_s && (brk_clr_pend_reg || (rd && paddr == OFS_STAT && rd_snap_reg[ST_BKD]))) begin
        bkd_reg <= 1'b0;
        brk_clr_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear-to-send change flag; a fresh edge wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcts_reg <= 1'b0;
    end else if (cts_prev_reg != cts_sync_reg[1]) begin
      dcts_reg <= 1'b1;
    end else if (rd && paddr == OFS_ICTL && rd_snap_reg[IC_DCTS]) begin
      dcts_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses on the rising edge of each flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_reg <= 1'b0;
      tbe_prev_reg <= ICTL_RESET[IC_TBE];
      rbf_prev_reg <= 1'b0;
      dcts_prev_reg <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      rx_err_irq <= 1'b0;
      flow_irq <= 1'b0;
    end else begin
      err_prev_reg <= err_sum;
      tbe_prev_reg <= tbe_reg;
      rbf_prev_reg <= rbf_reg;
      dcts_prev_reg <= dcts_reg;
      flow_irq <= ien_reg[0] & dcts_reg & ~dcts_prev_reg;
      tx_irq <= ien_reg[1] & ~mode_reg[MD_TXDMA] & tbe_reg & ~tbe_prev_reg;
      rx_irq <= ien_reg[2] & ~mode_reg[MD_RXDMA] & rbf_reg & ~rbf_prev_reg;
      rx_err_irq <= ien_reg[3] & err_sum & ~err_prev_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_frame_with_error;
    rx_done && rx_parity_bad;
  endsequence
  sequence s_parity_flag_up;
    ##1 pe_reg;
  endsequence
  property p_break_holds_low;
    @(posedge pclk) disable iff (!presetn) mode_reg[MD_BRK] |=> !txd_out;
  endproperty
  a_break_holds_low: assert property (p_break_holds_low) else $error("txd not low in break");
  property p_rts_inverted;
    @(posedge pclk) disable iff (!presetn) ##1 rts_n_out == !$past(mode_reg[MD_RTS]);
  endproperty
  a_rts_inverted: assert property (p_rts_inverted) else $error("rts not inverse of control");
  property p_parity_set;
    @(posedge pclk) disable iff (!presetn) s_frame_with_error |-> s_parity_flag_up;
  endproperty
  a_parity_set: assert property (p_parity_set) else $error("parity flag not set");
  // Checked on the bus copy, so a broken snapshot or bit map shows up too
  property p_err_summary;
    @(posedge pclk) disable iff (!presetn)
      access && !pwrite && paddr == OFS_STAT |-> prdata[ST_ERR] == (prdata[ST_PE] || prdata[ST_FE] || prdata[ST_OE]);
  endproperty
  a_err_summary: assert property (p_err_summary) else $error("error summary wrong");
  property p_tbe_set;
    @(posedge pclk) disable iff (!presetn) tx_load |=> tbe_reg;
  endproperty
  a_tbe_set: assert property (p_tbe_set) else $error("empty flag not set on load");
  property p_rbf_set;
    @(posedge pclk) disable iff (!presetn) rx_done |=> rbf_reg && rxbuf_reg == $past(rx_data[7:0]);
  endproperty
  a_rbf_set: assert property (p_rbf_set) else $error("full flag or data not captured");
  property p_cts_change;
    @(posedge pclk) disable iff (!presetn) $changed(cts_sync_reg[1]) |=> dcts_reg;
  endproperty
  a_cts_change: assert property (p_cts_change) else $error("cts change not flagged");
  property p_tx_irq_dma;
    @(posedge pclk) disable iff (!presetn) mode_reg[MD_TXDMA] |=> !tx_irq;
  endproperty
  a_tx_irq_dma: assert property (p_tx_irq_dma) else $error("tx irq while dma");
  property p_rx_irq_rise;
    @(posedge pclk) disable iff (!presetn)
      $rose(rbf_reg) && ien_reg[2] && !mode_reg[MD_RXDMA] |=> rx_irq ##1 !rx_irq;
  endproperty
  a_rx_irq_rise: assert property (p_rx_irq_rise) else $error("rx irq pulse missing");
  property p_break_stays;
    @(posedge pclk) disable iff (!presetn) bkd_reg && !rxd_s |=> bkd_reg;
  endproperty
  a_break_stays: assert property (p_break_stays) else $error("break cleared while line low");
  property p_status_ro;
    @(posedge pclk) disable iff (!presetn) wr && paddr == OFS_STAT && !rx_done |=> $stable(err_sum);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");
endmodule // uart_mode_status_irq_ctrl
`default_nettype wire

// [bench/far_end.sv]
// Far-side model: transmitter and receiver cores plus the serial lines
`default_nettype none
module far_end (
  input wire logic clk,
  output logic rxd,
  output logic cts_n,
  output logic tx_serial,
  output logic tx_busy,
  output logic tx_load,
  output logic rx_done,
  output logic [8:0] rx_data,
  output logic rx_parity_bad,
  output logic rx_stop_bad,
  output logic bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
    tx_serial = 1'b1;
    tx_busy = 1'b0;
    tx_load = 1'b0;
    rx_done = 1'b0;
    rx_data = 9'h1FF;
    rx_parity_bad = 1'b1;
    rx_stop_bad = 1'b1;
    bit_tick = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Qualifiers are scrambled outside the done pulse so a stale capture shows
  task automatic send(input logic [8:0] d, input logic pe, input logic se);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_data <= d;
    rx_parity_bad <= pe;
    rx_stop_bad <= se;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_data <= ~d;
    rx_parity_bad <= ~pe;
    rx_stop_bad <= ~se;
  endtask
  task automatic load();
    @(posedge clk);
    tx_load <= 1'b1;
    @(posedge clk);
    tx_load <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic lines(input logic r, input logic c, input logic b);
    @(posedge clk);
    rxd <= r;
    cts_n <= c;
    tx_busy <= b;
  endtask
endmodule // far_end
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the serial port control block
`default_nettype none
module tb_top;
  import uart_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic rxd_pin, cts_n_pin, tx_serial, tx_busy, tx_load, rx_done, rx_parity_bad, rx_stop_bad;
  logic nine_bit_mode, bit_tick, txd_out, rts_n_out, tx_enable, tx_dma_req, rx_dma_req;
  logic tx_irq, rx_irq, rx_err_irq, flow_irq;
  logic [8:0] rx_data;
  int failures, checks, cycles, n_tx, n_rx, n_er, n_fl;
  uart_mode_status_irq_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rxd_pin, .cts_n_pin, .tx_serial, .tx_busy, .tx_load, .rx_done,
    .rx_data, .rx_parity_bad, .rx_stop_bad, .nine_bit_mode, .bit_tick, .txd_out, .rts_n_out,
    .tx_enable, .tx_data, .tx_dma_req, .rx_dma_req, .tx_irq, .rx_irq, .rx_err_irq, .flow_irq);
  far_end far (.clk(pclk), .rxd(rxd_pin), .cts_n(cts_n_pin), .tx_serial, .tx_busy, .tx_load,
    .rx_done, .rx_data, .rx_parity_bad, .rx_stop_bad, .bit_tick);
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Pulses are counted rather than caught, so a double pulse is seen too
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (tx_irq === 1'b1) n_tx++;
    if (rx_irq === 1'b1) n_rx++;
    if (rx_err_irq === 1'b1) n_er++;
    if (flow_irq === 1'b1) n_fl++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One setup and one access phase; a wait state would simply be waited out
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input bit en = 1'b1);
    bus(1'b0, a, 32'h0000_0000);
    if (en) cmp(rdat, exp);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {failures, checks, cycles, n_tx, n_rx, n_er, n_fl} = '0;
    {psel, penable, pwrite, nine_bit_mode} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, 32'h00);
    rd(OFS_STAT, 32'h00);
    rd(OFS_ICTL, 32'h01);
    cmp(rts_n_out, 1'b1);
    $display("test reset done");
    wr(OFS_MODE, 32'hF6);
    rd(OFS_MODE, 32'hF6);
    cmp(rts_n_out, 1'b0);
    cmp(txd_out, 1'b0);
    cmp(tx_dma_req, 1'b1);
    cmp(tx_enable, 1'b0);
    wr(OFS_MODE, 32'h00);
    repeat (2) @(posedge pclk);
    cmp(rts_n_out, 1'b1);
    cmp(txd_out, 1'b1);
    wr(OFS_STAT, 32'hFF);
    rd(OFS_STAT, 32'h00);
    rd(8'h20, 32'h00);
    cmp(rerr, 1'b1);
    wr(OFS_ICTL, 32'hFF);
    rd(OFS_ICTL, 32'h3D);
    $display("test registers done");
    wr(OFS_TXBUF, 32'hA5);
    rd(OFS_ICTL, 32'h3C);
    // Looked at only after a later edge: the write edge itself launches it
    cmp(tx_data, 8'hA5);
    far.load();
    repeat (3) @(posedge pclk);
    rd(OFS_ICTL, 32'h3D);
    cmp(n_tx, 1);
    wr(OFS_MODE, 32'h10);
    wr(OFS_TXBUF, 32'h5A);
    far.load();
    repeat (3) @(posedge pclk);
    cmp(tx_dma_req, 1'b1);
    cmp(n_tx, 1);
    wr(OFS_MODE, 32'h00);
    far.lines(1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    rd(OFS_STAT, 32'h80);
    far.lines(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    rd(OFS_STAT, 32'h00);
    $display("test transmit done");
    far.send(9'h0C3, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    rd(OFS_ICTL, 32'h3F);
    cmp(n_rx, 1);
    rd(OFS_RXBUF, 32'hC3);
    rd(OFS_ICTL, 32'h3D);
    far.send(9'h001, 1'b0, 1'b0);
    far.send(9'h002, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    rd(OFS_STAT, 32'h18);
    cmp(n_er, 1);
    rd(OFS_STAT, 32'h00);
    rd(OFS_RXBUF, 32'h00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      far.send(9'h011, i == 0, i == 1);
      repeat (3) @(posedge pclk);
      rd(OFS_RXBUF, 32'h11);
      rd(OFS_STAT, (i == 0) ? 32'h12 : 32'h14);
    end
    cmp(n_er, 3);
    wr(OFS_MODE, 32'h20);
    far.send(9'h022, 1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    cmp(rx_dma_req, 1'b1);
    cmp(n_rx, 4);
    cmp(n_er, 4);
    rd(OFS_STAT, 32'h12);
    rd(OFS_RXBUF, 32'h22);
    wr(OFS_MODE, 32'h00);
    $display("test receive done");
    nine_bit_mode <= 1'b1;
    wr(OFS_MODE, 32'h02);
    far.send(9'h155, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    rd(OFS_MODE, 32'h00);
    rd(OFS_STAT, 32'h40);
    rd(OFS_RXBUF, 32'h00, 1'b0);
    nine_bit_mode <= 1'b0;
    $display("test address frame done");
    far.lines(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    far.send(9'h000, 1'b0, 1'b1);
    far.ticks(9);
    rd(OFS_STAT, 32'h14);
    far.ticks(1);
    repeat (3) @(posedge pclk);
    rd(OFS_STAT, 32'h20);
    rd(OFS_STAT, 32'h20);
    far.lines(1'b1, 1'b1, 1'b0);
    repeat (5) @(posedge pclk);
    rd(OFS_STAT, 32'h00);
    rd(OFS_RXBUF, 32'h00, 1'b0);
    $display("test break done");
    far.lines(1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge pclk);
    rd(OFS_ICTL, 32'hFD);
    cmp(n_fl, 1);
    rd(OFS_ICTL, 32'hBD);
    far.lines(1'b1, 1'b1, 1'b0);
    repeat (5) @(posedge pclk);
    rd(OFS_ICTL, 32'h7D);
    cmp(n_fl, 2);
    $display("test flow control done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
